//--- ssr_pkg.sv
// package of constants for the status summary byte and its lower sum registers
// Functional notes
// - bit 6 summarises enabled other bits
// - query and serial poll return current byte
// - each bit masked; mask bit 6 ignored
// - enabled bit rising raises service request
// - mask write stored, query returns it
// - error queue entry sets bit 2, requests
// - bit 3 is questionable sum
// - bit 4 shows response data available
// - bit 5 is event status sum
// - bit 7 is operation sum
// - lower sum: OR of event AND enable
// - event read clears event and contribution
package ssr_pkg;
    localparam int SSR_BYTE_W = 8;
    localparam int SSR_SCPI_W = 16;
    localparam int SSR_ESR_W = 8;
    localparam int SSR_BIT_ERRQ = 2;
    localparam int SSR_BIT_QUES = 3;
    localparam int SSR_BIT_MAV = 4;
    localparam int SSR_BIT_ESB = 5;
    localparam int SSR_BIT_MSS = 6;
    localparam int SSR_BIT_OPER = 7;
    localparam logic [7:0] SSR_UNUSED_MASK = 8'h03;
    localparam logic [7:0] SSR_MSS_MASK = 8'h40;
    localparam logic [7:0] SSR_MASK_RESET = 8'h00;
    localparam logic [15:0] SSR_EVT_RESET = 16'h0000;
    localparam logic [15:0] SSR_EN_RESET = 16'h0000;
endpackage : ssr_pkg

`timescale 1ns/1ps

// =====================================================
// lower register: sticky events, enable, sum bit
module ssr_sum_reg #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk_sys,                  // system clock
    input wire logic i_sys_rst,                  // sync reset, high
    input wire logic [WIDTH-1:0] i_evt_set,      // event set pulses
    input wire logic i_en_wr,                    // enable write strobe
    input wire logic [WIDTH-1:0] i_en_wdata,     // enable write value
    input wire logic i_evt_rd,                   // event read strobe
    output logic [WIDTH-1:0] o_evt_rd_data_q,    // event value captured by read
    output logic [WIDTH-1:0] o_en_q,             // enable part
    output logic o_sum_q                         // sum bit
);
    import ssr_pkg::*;

    initial begin
        if (WIDTH < 1 || WIDTH > SSR_SCPI_W) begin
            $error("ssr_sum_reg: WIDTH out of range");
        end
    end

    logic [WIDTH-1:0] evt_q;
    logic [WIDTH-1:0] evt_d;
    logic [WIDTH-1:0] en_d;
    logic [WIDTH-1:0] rd_d;
    logic sum_d;

    always_comb begin
        rd_d = o_evt_rd_data_q;
        evt_d = evt_q;
        en_d = o_en_q;
        if (i_evt_rd) begin
            rd_d = evt_q;
            evt_d = '0;
        end
        evt_d = evt_d | i_evt_set;               // set wins over read clear
        if (i_en_wr) begin
            en_d = i_en_wdata;
        end
        sum_d = |(evt_d & en_d);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            evt_q <= SSR_EVT_RESET[WIDTH-1:0];
            o_en_q <= SSR_EN_RESET[WIDTH-1:0];
            o_evt_rd_data_q <= '0;
            o_sum_q <= 1'b0;
        end else begin
            evt_q <= evt_d;
            o_en_q <= en_d;
            o_evt_rd_data_q <= rd_d;
            o_sum_q <= sum_d;
        end
    end
endmodule : ssr_sum_reg

//--- ssr_status_byte.sv
// status summary byte, service request mask and request generation
`timescale 1ns/1ps

module ssr_status_byte (
    input wire logic i_clk_sys,                         // system clock, 200 MHz
    input wire logic i_sys_rst,                         // sync reset, high
    // error queue and output buffer
    input wire logic i_errq_push,                       // pulse: entry added to error queue
    input wire logic i_errq_not_empty,                  // level: error queue holds entries
    input wire logic i_msg_avail,                       // level: response data readable
    // questionable register
    input wire logic [ssr_pkg::SSR_SCPI_W-1:0] i_ques_evt_set,  // questionable event set pulses
    input wire logic i_ques_en_wr,                      // questionable enable write
    input wire logic i_ques_evt_rd,                     // questionable event read (clears)
    output logic [ssr_pkg::SSR_SCPI_W-1:0] o_ques_evt_q,        // questionable event read data
    output logic [ssr_pkg::SSR_SCPI_W-1:0] o_ques_en_q,         // questionable enable
    // operation register
    input wire logic [ssr_pkg::SSR_SCPI_W-1:0] i_oper_evt_set,  // operation event set pulses
    input wire logic i_oper_en_wr,                      // operation enable write
    input wire logic i_oper_evt_rd,                     // operation event read (clears)
    output logic [ssr_pkg::SSR_SCPI_W-1:0] o_oper_evt_q,        // operation event read data
    output logic [ssr_pkg::SSR_SCPI_W-1:0] o_oper_en_q,         // operation enable
    // event status register
    input wire logic [ssr_pkg::SSR_ESR_W-1:0] i_esr_evt_set,    // event status set pulses
    input wire logic i_esr_en_wr,                       // event status enable write
    input wire logic i_esr_evt_rd,                      // event status read (clears)
    output logic [ssr_pkg::SSR_ESR_W-1:0] o_esr_evt_q,          // event status read data
    output logic [ssr_pkg::SSR_ESR_W-1:0] o_esr_en_q,           // event status enable
    // shared enable write data, low bits used for the byte wide enable
    input wire logic [ssr_pkg::SSR_SCPI_W-1:0] i_en_wdata,      // enable write value
    // status byte and mask commands
    input wire logic i_stb_query,                       // pulse: status byte query
    input wire logic i_serial_poll,                     // pulse: serial poll
    input wire logic i_mask_wr,                         // pulse: mask write
    input wire logic [ssr_pkg::SSR_BYTE_W-1:0] i_mask_wdata,    // mask write value
    input wire logic i_mask_query,                      // pulse: mask query
    output logic [ssr_pkg::SSR_BYTE_W-1:0] o_resp_data_q,       // answer byte
    output logic o_resp_valid_q,                        // pulse: answer valid
    output logic [ssr_pkg::SSR_BYTE_W-1:0] o_mask_q,            // service request mask
    output logic o_mss_q,                               // master summary bit
    output logic o_srq_q                                // service request to controller
);
    import ssr_pkg::*;

    logic ques_sum;
    logic oper_sum;
    logic esb_sum;

    // =====================================================
    // lower registers
    ssr_sum_reg #(.WIDTH(SSR_SCPI_W)) u_ques (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_evt_set(i_ques_evt_set),
        .i_en_wr(i_ques_en_wr),
        .i_en_wdata(i_en_wdata),
        .i_evt_rd(i_ques_evt_rd),
        .o_evt_rd_data_q(o_ques_evt_q),
        .o_en_q(o_ques_en_q),
        .o_sum_q(ques_sum)
    );

    ssr_sum_reg #(.WIDTH(SSR_SCPI_W)) u_oper (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_evt_set(i_oper_evt_set),
        .i_en_wr(i_oper_en_wr),
        .i_en_wdata(i_en_wdata),
        .i_evt_rd(i_oper_evt_rd),
        .o_evt_rd_data_q(o_oper_evt_q),
        .o_en_q(o_oper_en_q),
        .o_sum_q(oper_sum)
    );

    ssr_sum_reg #(.WIDTH(SSR_ESR_W)) u_esr (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_evt_set(i_esr_evt_set),
        .i_en_wr(i_esr_en_wr),
        .i_en_wdata(i_en_wdata[SSR_ESR_W-1:0]),
        .i_evt_rd(i_esr_evt_rd),
        .o_evt_rd_data_q(o_esr_evt_q),
        .o_en_q(o_esr_en_q),
        .o_sum_q(esb_sum)
    );

    // =====================================================
    // status byte and request state
    logic [7:0] stb_raw;
    logic [7:0] enabled;
    logic [7:0] enabled_q;
    logic [7:0] enabled_d;
    logic [7:0] mask_d;
    logic [7:0] resp_data_d;
    logic [7:0] stb_now;
    logic resp_valid_d;
    logic mss_d;
    logic srq_d;
    logic new_req;

    always_comb begin
        stb_raw = '0;
        stb_raw[SSR_BIT_ERRQ] = i_errq_not_empty;
        stb_raw[SSR_BIT_QUES] = ques_sum;
        stb_raw[SSR_BIT_MAV] = i_msg_avail;
        stb_raw[SSR_BIT_ESB] = esb_sum;
        stb_raw[SSR_BIT_OPER] = oper_sum;
        enabled = stb_raw & o_mask_q & ~SSR_MSS_MASK & ~SSR_UNUSED_MASK;
        enabled_d = enabled;
        mss_d = |enabled;
        stb_now = stb_raw;
        stb_now[SSR_BIT_MSS] = mss_d;                    // same cycle as the other bits
        // rising enabled bit, or any new error entry while enabled
        new_req = |(enabled & ~enabled_q)
            | (i_errq_push & o_mask_q[SSR_BIT_ERRQ]);
        srq_d = o_srq_q;
        if (i_serial_poll) begin
            srq_d = 1'b0;
        end
        if (!mss_d) begin
            srq_d = 1'b0;
        end
        if (new_req) begin
            srq_d = 1'b1;                                // set wins over poll clear
        end
        mask_d = o_mask_q;
        if (i_mask_wr) begin
            mask_d = i_mask_wdata;
        end
        resp_valid_d = 1'b0;
        resp_data_d = o_resp_data_q;
        if (i_stb_query || i_serial_poll) begin
            resp_valid_d = 1'b1;
            resp_data_d = stb_now;
        end else if (i_mask_query) begin
            resp_valid_d = 1'b1;
            resp_data_d = o_mask_q;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_mask_q <= SSR_MASK_RESET;
            enabled_q <= '0;
            o_mss_q <= 1'b0;
            o_srq_q <= 1'b0;
            o_resp_data_q <= '0;
            o_resp_valid_q <= 1'b0;
        end else begin
            o_mask_q <= mask_d;
            enabled_q <= enabled_d;
            o_mss_q <= mss_d;
            o_srq_q <= srq_d;
            o_resp_data_q <= resp_data_d;
            o_resp_valid_q <= resp_valid_d;
        end
    end
endmodule : ssr_status_byte

//--- ssr_status_byte_asserts.sv
// checker of the status byte port timing
`timescale 1ns/1ps
module ssr_status_byte_asserts (
    input wire logic i_clk_sys, // clock
    input wire logic i_sys_rst, // reset
    input wire logic i_errq_push, // push
    input wire logic i_stb_query, // query
    input wire logic i_serial_poll, // poll
    input wire logic i_mask_wr, // write
    input wire logic i_mask_query, // query
    input wire logic [ssr_pkg::SSR_BYTE_W-1:0] i_mask_wdata, // value
    input wire logic [ssr_pkg::SSR_BYTE_W-1:0] o_resp_data_q, // answer
    input wire logic o_resp_valid_q, // valid
    input wire logic [ssr_pkg::SSR_BYTE_W-1:0] o_mask_q, // mask
    input wire logic o_mss_q, // summary
    input wire logic o_srq_q // request
);
    import ssr_pkg::*;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    wire stb_rd = i_stb_query | i_serial_poll;
    // ==========
    // assertions
    a_resp_one_cycle: assert property ((stb_rd | i_mask_query) |=> o_resp_valid_q) else $error("no answer");
    a_mask_store: assert property (i_mask_wr |=> o_mask_q == $past(i_mask_wdata)) else $error("mask lost");
    a_mask_hold: assert property (!i_mask_wr |=> $stable(o_mask_q)) else $error("mask moved");
    a_mask_echo: assert property (i_mask_query && !stb_rd |=> o_resp_data_q == $past(o_mask_q)) else $error("echo");
    a_unused_zero: assert property (stb_rd |=> o_resp_data_q[1:0] == 2'h0) else $error("unused set");
    a_summary_bit: assert property (stb_rd |=> o_resp_data_q[6] == o_mss_q) else $error("bit six");
    a_summary_match: assert property (stb_rd && !i_mask_wr |=>
        o_resp_data_q[6] == |(o_resp_data_q & o_mask_q & 8'hBC)) else $error("bit six mismatch");
    a_srq_cause: assert property ($rose(o_srq_q) |-> o_mss_q || $past(i_errq_push)) else $error("stray srq");
    a_srq_fall: assert property ($fell(o_mss_q) |-> !o_srq_q) else $error("srq stuck");
    a_errq_srq: assert property (i_errq_push && o_mask_q[2] |=> o_srq_q) else $error("no errq srq");
    c_srq_read: cover property (o_srq_q && o_resp_valid_q);
    c_mss_fall: cover property ($fell(o_mss_q));
    c_errq_push: cover property (i_errq_push && o_mask_q[2]);
endmodule : ssr_status_byte_asserts

//--- ssr_ctrl_model.sv
// remote controller model issuing queries, polls and mask writes
`timescale 1ns/1ps
module ssr_ctrl_model (
    input wire logic i_clk_sys, // clock
    input wire logic i_valid, // answer valid
    input wire logic [ssr_pkg::SSR_BYTE_W-1:0] i_data, // answer
    output logic [3:0] o_cmd, // query, poll, mask query, mask write
    output logic [ssr_pkg::SSR_BYTE_W-1:0] o_wdata // mask value
);
    import ssr_pkg::*;
    initial o_cmd = 4'h0;
    initial o_wdata = 8'h00;
    // ==========
    // one pulse per command, answer taken one cycle on
    task automatic xfer(input int k, input logic [7:0] wd, output logic [7:0] rd);
        @(negedge i_clk_sys);
        o_cmd = 4'h1 << k;
        o_wdata = wd;
        @(negedge i_clk_sys);
        o_cmd = 4'h0;
        o_wdata = ~wd;
        rd = (i_valid || k == 3) ? i_data : ~i_data;
    endtask : xfer
endmodule : ssr_ctrl_model

//--- ssr_status_byte_tb.sv
// testbench of the status byte and service request block
`timescale 1ns/1ps
module ssr_status_byte_tb;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_errq_push, i_errq_not_empty, i_msg_avail, i_ques_en_wr, i_oper_en_wr, i_esr_en_wr;
    logic i_ques_evt_rd, i_oper_evt_rd, i_esr_evt_rd, o_resp_valid_q, o_mss_q, o_srq_q;
    logic [15:0] i_ques_evt_set, i_oper_evt_set, i_en_wdata, o_ques_evt_q, o_ques_en_q, o_oper_evt_q, o_oper_en_q;
    logic [7:0] i_esr_evt_set, i_mask_wdata, o_esr_evt_q, o_esr_en_q, o_resp_data_q, o_mask_q, rd, s;
    logic [3:0] cmd;
    wire i_stb_query = cmd[0], i_serial_poll = cmd[1], i_mask_query = cmd[2], i_mask_wr = cmd[3];
    int err_count = 0, compares = 0, bits[5] = '{2, 3, 4, 5, 7};
    always #2.5 i_clk_sys = ~i_clk_sys;
    ssr_status_byte dut (.*);
    ssr_ctrl_model ctl (.i_clk_sys(i_clk_sys), .i_valid(o_resp_valid_q), .i_data(o_resp_data_q),
        .o_cmd(cmd), .o_wdata(i_mask_wdata));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
        compares++;
        if (v !== e) begin
            $display("MISMATCH %s exp %h got %h", n, e, v);
            err_count++;
        end
    endtask : chk
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    // ==========
    // raise or clear one status byte source
    task automatic src(input int b, input logic on);
        @(negedge i_clk_sys);
        s = on ? 8'h01 << b : 8'h00;
        {i_errq_not_empty, i_errq_push, i_msg_avail} = {s[2], s[2], s[4]};
        {i_ques_evt_set[3], i_esr_evt_set[0], i_oper_evt_set[0]} = {s[3], s[5], s[7]};
        {i_ques_evt_rd, i_esr_evt_rd, i_oper_evt_rd} = on ? 3'h0 : {b == 3, b == 5, b == 7};
        @(negedge i_clk_sys);
        {i_errq_push, i_ques_evt_set, i_esr_evt_set, i_oper_evt_set, i_ques_evt_rd, i_esr_evt_rd, i_oper_evt_rd} = '0;
        repeat (4) @(negedge i_clk_sys);
    endtask : src
    initial begin
        {i_errq_push, i_errq_not_empty, i_msg_avail, i_ques_en_wr, i_oper_en_wr, i_esr_en_wr} = '0;
        {i_ques_evt_rd, i_oper_evt_rd, i_esr_evt_rd, i_ques_evt_set, i_oper_evt_set, i_esr_evt_set} = '0;
        i_en_wdata = 16'hFFFF;
        repeat (8) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        ctl.xfer(2, 8'h00, rd);
        chk("mask reset", 8'h00, rd);
        ctl.xfer(0, 8'h00, rd);
        chk("byte reset", 8'h00, rd);
        {i_ques_en_wr, i_oper_en_wr, i_esr_en_wr} = 3'h7;
        @(negedge i_clk_sys);
        {i_ques_en_wr, i_oper_en_wr, i_esr_en_wr} = 3'h0;
        ctl.xfer(3, 8'hFF, rd);
        ctl.xfer(2, 8'h00, rd);
        chk("mask readback", 8'hFF, rd);
        chk("ques enable", 16'hFFFF, o_ques_en_q);
        chk("oper enable", 16'hFFFF, o_oper_en_q);
        chk("esr enable", 16'h00FF, o_esr_en_q);
        $display("test reset_and_mask done");
        foreach (bits[i]) begin
            src(bits[i], 1'b1);
            chk("srq", 1'b1, o_srq_q);
            ctl.xfer(0, 8'h00, rd);
            chk("byte query", 8'h40 | (8'h01 << bits[i]), rd);
            ctl.xfer(1, 8'h00, rd);
            chk("serial poll", 8'h40 | (8'h01 << bits[i]), rd);
            src(bits[i], 1'b0);
            ctl.xfer(0, 8'h00, rd);
            chk("byte cleared", 8'h00, rd);
        end
        chk("ques read data", 16'h0008, o_ques_evt_q);
        chk("oper read data", 16'h0001, o_oper_evt_q);
        chk("esr read data", 16'h0001, o_esr_evt_q);
        $display("test sources done");
        ctl.xfer(3, 8'h40, rd);
        src(3, 1'b1);
        chk("masked srq", 1'b0, o_srq_q);
        ctl.xfer(0, 8'h00, rd);
        chk("masked byte", 8'h08, rd);
        $display("test mask_gate done");
        // every new error entry requests again, even with bit 2 already set
        ctl.xfer(3, 8'h04, rd);
        src(2, 1'b1);
        chk("errq srq", 1'b1, o_srq_q);
        ctl.xfer(1, 8'h00, rd);
        chk("errq poll", 8'h4C, rd);
        chk("srq after poll", 1'b0, o_srq_q);
        @(negedge i_clk_sys);
        i_errq_push = 1'b1;
        @(negedge i_clk_sys);
        i_errq_push = 1'b0;
        chk("errq repeat srq", 1'b1, o_srq_q);
        $display("test errq_repeat done");
        // event set in the read cycle survives the clear
        @(negedge i_clk_sys);
        {i_ques_evt_rd, i_ques_evt_set[5]} = 2'h3;
        @(negedge i_clk_sys);
        {i_ques_evt_rd, i_ques_evt_set[5]} = 2'h0;
        chk("read before set", 16'h0008, o_ques_evt_q);
        @(negedge i_clk_sys);
        i_ques_evt_rd = 1'b1;
        @(negedge i_clk_sys);
        i_ques_evt_rd = 1'b0;
        chk("set kept", 16'h0020, o_ques_evt_q);
        $display("test set_wins done");
        summarize();
    end
    initial begin
        #50000;
        err_count++;
        summarize();
    end
endmodule : ssr_status_byte_tb
bind ssr_status_byte ssr_status_byte_asserts u_chk (.*);
